// [verilog/asfr_regs.sv]
// Purpose: Serial-port register tail with sync control and misc controls.
// Assumes: Pins are asynchronous and oversampled by the 250 MHz clock.
// Notes: Channel select picks which local copies a write reaches.
`timescale 1ns/1ps
`default_nettype none
module asfr_regs
#(
	parameter int NUM_CH = 2
)
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic resetn_i,
	// Serial configuration port pins.
	input wire logic serial_port_select_bar_i,
	input wire logic sclk_i,
	input wire logic sdio_i,
	output logic sdio_o,
	output logic sdio_oe_o,
	// Channel index and self-test input.
	input wire logic [NUM_CH-1:0] chan_sel_i,
	input wire logic [15:0] self_test_signature_i,
	// Clocking unit.
	input wire logic sync_pin_i,
	input wire logic encode_pin_i,
	input wire logic [asfr_pkg::DIV_RATIO_W-1:0] div_ratio_i,
	output logic div_tick_o,
	output logic div_resync_o,
	// Control outputs.
	output logic [15:0] user_pattern_two_o,
	output logic [NUM_CH-1:0] or_pin_enable_o,
	output logic [NUM_CH-1:0] out_assign_b_o,
	output logic output_enable_bar_pin_en_o,
	output logic low_rate_internal_oscillator_on_o,
	output logic low_rate_detected_o,
	output logic sdio_pulldown_en_o
);
	typedef enum logic [1:0] {ASFR_IDLE, ASFR_INSTR, ASFR_DATA} asfr_state_t;
	// Two-flop synchronisers on every pin; stage one feeds stage two only.
	logic [4:0] pin_meta_reg;
	logic [4:0] pin_sync_reg;
	logic [4:0] pin_prev_reg;
	logic [4:0] pins;
	assign pins = {encode_pin_i, sync_pin_i, sdio_i, sclk_i,
		serial_port_select_bar_i};
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			pin_meta_reg <= 5'h01;
			pin_sync_reg <= 5'h01;
			pin_prev_reg <= 5'h01;
		end
		else
		begin
			pin_meta_reg <= pins;
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg;
		end
	end
	logic csb_s;
	logic sclk_rise;
	logic sclk_fall;
	logic sdio_s;
	logic sync_rise;
	logic enc_rise;
	// Edges are taken from the second and third stages only.
	assign csb_s = pin_sync_reg[0];
	assign sclk_rise = pin_sync_reg[1] & ~pin_prev_reg[1] & ~csb_s;
	assign sclk_fall = ~pin_sync_reg[1] & pin_prev_reg[1] & ~csb_s;
	assign sdio_s = pin_sync_reg[2];
	assign sync_rise = pin_sync_reg[3] & ~pin_prev_reg[3];
	assign enc_rise = pin_sync_reg[4] & ~pin_prev_reg[4];
	// Serial frame state.
	asfr_state_t state_reg;
	logic [15:0] instr_reg;
	logic [4:0] bit_cnt_reg;
	logic [7:0] rx_reg;
	logic [7:0] tx_reg;
	logic [12:0] addr_reg;
	logic is_read_reg;
	logic wr_stb;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	logic [12:0] rd_addr;
	// A byte completes on the eighth rising edge of the data phase.
	assign wr_stb = (state_reg == ASFR_DATA) && sclk_rise && !is_read_reg
		&& (bit_cnt_reg == 5'h07);
	assign wr_data = {rx_reg[6:0], sdio_s};
	assign rd_addr = (state_reg == ASFR_INSTR) ? {instr_reg[11:0], sdio_s}
		: addr_reg - 13'h0001;
	// Frame sequencer; streaming continues with a decrementing address.
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			state_reg <= ASFR_IDLE;
			instr_reg <= 16'h0000;
			bit_cnt_reg <= 5'h00;
			rx_reg <= 8'h00;
			addr_reg <= 13'h0000;
			is_read_reg <= 1'b0;
		end
		else if (csb_s)
		begin
			state_reg <= ASFR_IDLE;
			bit_cnt_reg <= 5'h00;
		end
		else
		begin
			case (state_reg)
				ASFR_IDLE:
				begin
					state_reg <= ASFR_INSTR;
					bit_cnt_reg <= 5'h00;
				end
				ASFR_INSTR:
				begin
					if (sclk_rise)
					begin
						instr_reg <= {instr_reg[14:0], sdio_s};
						if (bit_cnt_reg == 5'(asfr_pkg::INSTR_BITS - 1))
						begin
							state_reg <= ASFR_DATA;
							bit_cnt_reg <= 5'h00;
							addr_reg <= {instr_reg[11:0], sdio_s};
							is_read_reg <= instr_reg[asfr_pkg::RW_BIT - 1];
						end
						else
						begin
							bit_cnt_reg <= bit_cnt_reg + 5'h01;
						end
					end
				end
				ASFR_DATA:
				begin
					if (sclk_rise)
					begin
						rx_reg <= wr_data;
						if (bit_cnt_reg == 5'(asfr_pkg::BYTE_BITS - 1))
						begin
							bit_cnt_reg <= 5'h00;
							addr_reg <= addr_reg - 13'h0001;
						end
						else
						begin
							bit_cnt_reg <= bit_cnt_reg + 5'h01;
						end
					end
				end
				default:
				begin
					state_reg <= ASFR_IDLE;
				end
			endcase
		end
	end
	// Read shifter: loaded at each byte boundary, shifted on falling edges.
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			tx_reg <= 8'h00;
			sdio_o <= 1'b0;
		end
		else if (sclk_rise && ((state_reg == ASFR_INSTR
			&& bit_cnt_reg == 5'(asfr_pkg::INSTR_BITS - 1))
			|| (state_reg == ASFR_DATA
			&& bit_cnt_reg == 5'(asfr_pkg::BYTE_BITS - 1))))
		begin
			tx_reg <= rd_data;
		end
		else if (sclk_fall && state_reg == ASFR_DATA && is_read_reg)
		begin
			sdio_o <= tx_reg[7];
			tx_reg <= {tx_reg[6:0], 1'b0};
		end
	end
	// The device drives the data pin only during a read data phase.
	assign sdio_oe_o = (state_reg == ASFR_DATA) && is_read_reg && !csb_s;
	// Second user pattern bytes.
	logic [7:0] patt_low_reg;
	logic [7:0] patt_high_reg;
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			patt_low_reg <= asfr_pkg::RST_PATT2;
			patt_high_reg <= asfr_pkg::RST_PATT2;
		end
		else if (wr_stb && addr_reg == asfr_pkg::ADDR_PATT2_LOW)
		begin
			patt_low_reg <= wr_data;
		end
		else if (wr_stb && addr_reg == asfr_pkg::ADDR_PATT2_HIGH)
		begin
			patt_high_reg <= wr_data;
		end
	end
	assign user_pattern_two_o = {patt_high_reg, patt_low_reg};
	// Per-channel local bits; a write reaches every selected channel.
	logic [NUM_CH-1:0] or_en_reg;
	logic [NUM_CH-1:0] assign_reg;
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++)
		begin : g_chan
			always_ff @(posedge clk_i)
			begin
				if (!resetn_i)
				begin
					or_en_reg[ch] <= asfr_pkg::RST_FEATURES[0];
					assign_reg[ch] <= (ch == 1) ?
						asfr_pkg::RST_OUT_ASSIGN[1] :
						asfr_pkg::RST_OUT_ASSIGN[0];
				end
				else if (wr_stb && chan_sel_i[ch])
				begin
					if (addr_reg == asfr_pkg::ADDR_FEATURES)
					begin
						or_en_reg[ch] <= wr_data[0];
					end
					if (addr_reg == asfr_pkg::ADDR_OUT_ASSIGN)
					begin
						assign_reg[ch] <= wr_data[0];
					end
				end
			end
		end
	endgenerate
	assign or_pin_enable_o = or_en_reg;
	assign out_assign_b_o = assign_reg;
	// Sync control and pulse gating.
	logic [7:0] sync_ctrl_reg;
	logic sync_fire;
	// A pulse passes only with master and divider enables both set.
	assign sync_fire = sync_rise
		&& sync_ctrl_reg[asfr_pkg::SYNC_MASTER_BIT]
		&& sync_ctrl_reg[asfr_pkg::SYNC_DIV_EN_BIT];
	// In next-only mode the enable drops after the first sync, so later
	// pulses are blocked; a host write in the same cycle takes priority.
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			sync_ctrl_reg <= asfr_pkg::RST_SYNC_CTRL;
		end
		else if (wr_stb && addr_reg == asfr_pkg::ADDR_SYNC_CTRL)
		begin
			sync_ctrl_reg <= wr_data & asfr_pkg::SYNC_CTRL_MASK;
		end
		else if (sync_fire && sync_ctrl_reg[asfr_pkg::SYNC_NEXT_ONLY_BIT])
		begin
			sync_ctrl_reg[asfr_pkg::SYNC_DIV_EN_BIT] <= 1'b0;
		end
	end
	// Continuous mode resyncs on every gated pulse; reset masks it.
	logic resync_reg;
	always_ff @(posedge clk_i)
	begin
		resync_reg <= resetn_i && sync_fire;
	end
	assign div_resync_o = resync_reg;
	asfr_clk_div u_div
	(
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.ratio_i(div_ratio_i),
		.resync_i(resync_reg),
		.tick_o(div_tick_o),
		.phase_o()
	);
	// Miscellaneous user control.
	logic [7:0] misc_reg;
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			misc_reg <= asfr_pkg::RST_MISC_CTRL;
		end
		else if (wr_stb && addr_reg == asfr_pkg::ADDR_MISC_CTRL)
		begin
			misc_reg <= wr_data & asfr_pkg::MISC_CTRL_MASK;
		end
	end
	// Low encode-rate detector: a gap longer than the threshold period
	// means the encode clock is below about 5 MSPS.
	logic [7:0] gap_cnt_reg;
	logic slow_reg;
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			gap_cnt_reg <= 8'h00;
			slow_reg <= 1'b0;
		end
		else if (!misc_reg[asfr_pkg::MISC_DETECT_BIT])
		begin
			gap_cnt_reg <= 8'h00;
			slow_reg <= 1'b0;
		end
		else if (enc_rise)
		begin
			slow_reg <= (gap_cnt_reg >= 8'(asfr_pkg::SLOW_ENC_CYC));
			gap_cnt_reg <= 8'h00;
		end
		else if (gap_cnt_reg < 8'(asfr_pkg::SLOW_ENC_CYC))
		begin
			gap_cnt_reg <= gap_cnt_reg + 8'h01;
		end
		else
		begin
			slow_reg <= 1'b1;
		end
	end
	assign low_rate_detected_o = slow_reg;
	assign low_rate_internal_oscillator_on_o =
		misc_reg[asfr_pkg::MISC_RUN_OSC_BIT] | slow_reg;
	assign output_enable_bar_pin_en_o =
		misc_reg[asfr_pkg::MISC_OEB_EN_BIT];
	assign sdio_pulldown_en_o = ~misc_reg[asfr_pkg::MISC_PD_DIS_BIT];
	// Read mux; channel A answers when selected, otherwise channel B.
	logic rd_or;
	logic rd_asg;
	always_comb
	begin
		rd_or = chan_sel_i[0] ? or_en_reg[0] : or_en_reg[NUM_CH-1];
		rd_asg = chan_sel_i[0] ? assign_reg[0] : assign_reg[NUM_CH-1];
		case (rd_addr)
			asfr_pkg::ADDR_PATT2_LOW: rd_data = patt_low_reg;
			asfr_pkg::ADDR_PATT2_HIGH: rd_data = patt_high_reg;
			asfr_pkg::ADDR_SIG_LOW:
				rd_data = {7'h00, self_test_signature_i[0]};
			asfr_pkg::ADDR_FEATURES: rd_data = {7'h00, rd_or};
			asfr_pkg::ADDR_OUT_ASSIGN: rd_data = {7'h00, rd_asg};
			asfr_pkg::ADDR_SYNC_CTRL: rd_data = sync_ctrl_reg;
			asfr_pkg::ADDR_MISC_CTRL: rd_data = misc_reg;
			default: rd_data = 8'h00;
		endcase
	end
endmodule
`default_nettype wire

// [verilog/asfr_pkg.sv]
// Purpose: Shared constants for the sync and feature register tail.
// Assumes: Byte-wide registers behind a three-wire serial port.
// Notes: Offsets are the serial-port register addresses.
`default_nettype none
package asfr_pkg;
	// Serial frame layout.
	localparam int ADDR_W = 13;
	localparam int INSTR_BITS = 16;
	localparam int BYTE_BITS = 8;
	localparam int RW_BIT = 15;

	// Register addresses.
	localparam logic [12:0] ADDR_PATT2_LOW = 13'h001b;
	localparam logic [12:0] ADDR_PATT2_HIGH = 13'h001c;
	localparam logic [12:0] ADDR_SIG_LOW = 13'h0024;
	localparam logic [12:0] ADDR_FEATURES = 13'h002a;
	localparam logic [12:0] ADDR_OUT_ASSIGN = 13'h002e;
	localparam logic [12:0] ADDR_SYNC_CTRL = 13'h0100;
	localparam logic [12:0] ADDR_MISC_CTRL = 13'h0101;

	// Reset values.
	localparam logic [7:0] RST_PATT2 = 8'h00;
	localparam logic [7:0] RST_FEATURES = 8'h01;
	localparam logic [1:0] RST_OUT_ASSIGN = 2'h2;
	localparam logic [7:0] RST_SYNC_CTRL = 8'h01;
	localparam logic [7:0] RST_MISC_CTRL = 8'h88;

	// Field positions.
	localparam int SYNC_MASTER_BIT = 0;
	localparam int SYNC_DIV_EN_BIT = 1;
	localparam int SYNC_NEXT_ONLY_BIT = 2;
	localparam int MISC_PD_DIS_BIT = 0;
	localparam int MISC_RUN_OSC_BIT = 2;
	localparam int MISC_DETECT_BIT = 3;
	localparam int MISC_OEB_EN_BIT = 7;
	localparam logic [7:0] SYNC_CTRL_MASK = 8'h07;
	localparam logic [7:0] MISC_CTRL_MASK = 8'h8d;

	// Timing: encode period at the low-rate threshold of 5 MSPS.
	localparam int CLK_PERIOD_NS = 4;
	localparam int SLOW_ENC_PERIOD_NS = 200;
	localparam int SLOW_ENC_CYC = SLOW_ENC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int DIV_RATIO_W = 3;
endpackage
`default_nettype wire

// [verilog/asfr_clk_div.sv]
// Purpose: Integer 1-to-8 input clock divider with phase resync.
// Assumes: Ratio field holds divide-by minus one.
// Notes: A resync pulse restarts the phase at zero.
`timescale 1ns/1ps
`default_nettype none
module asfr_clk_div
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic resetn_i,
	// Control.
	input wire logic [asfr_pkg::DIV_RATIO_W-1:0] ratio_i,
	input wire logic resync_i,
	// Divided output.
	output logic tick_o,
	output logic [asfr_pkg::DIV_RATIO_W-1:0] phase_o
);
	logic [asfr_pkg::DIV_RATIO_W-1:0] cnt_reg;
	logic tick_reg;

	// Phase counter; resync forces a known phase so channels line up.
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end
		else if (resync_i)
		begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end
		else if (cnt_reg >= ratio_i)
		begin
			cnt_reg <= '0;
			tick_reg <= 1'b1;
		end
		else
		begin
			cnt_reg <= cnt_reg + 3'h1;
			tick_reg <= 1'b0;
		end
	end

	assign tick_o = tick_reg;
	assign phase_o = cnt_reg;
endmodule
`default_nettype wire

// [dv/asfr_props.sv]
// Purpose: Port-level checks for the sync and feature register tail.
// Assumes: Only the top module ports are visible.
// Notes: Bound into every instance of the register block.
`timescale 1ns/1ps
`default_nettype none
module asfr_props
#(
	parameter int NUM_CH = 2
)
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic resetn_i,
	// Watched pins and outputs.
	input wire logic serial_port_select_bar_i,
	input wire logic sync_pin_i,
	input wire logic div_resync_o,
	input wire logic sdio_oe_o,
	input wire logic [15:0] user_pattern_two_o,
	input wire logic [NUM_CH-1:0] or_pin_enable_o,
	input wire logic [NUM_CH-1:0] out_assign_b_o,
	input wire logic output_enable_bar_pin_en_o,
	input wire logic low_rate_internal_oscillator_on_o,
	input wire logic low_rate_detected_o,
	input wire logic sdio_pulldown_en_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	// Reset values show on the first edge after release.
	a_reset_vals: assert property ($rose(resetn_i) |->
		or_pin_enable_o == 2'b11 && out_assign_b_o == 2'b10 &&
		output_enable_bar_pin_en_o && sdio_pulldown_en_o &&
		user_pattern_two_o == 16'h0000)
		else $error("reset values wrong");
	// A divider resync must trace back to a recent sync pin edge.
	a_resync_cause: assert property (div_resync_o |->
		$past(sync_pin_i, 3) && !$past(sync_pin_i, 4))
		else $error("resync without sync pulse");
	a_resync_pulse: assert property (div_resync_o |=> !div_resync_o)
		else $error("resync wider than one cycle");
	a_detect_osc: assert property (low_rate_detected_o |->
		low_rate_internal_oscillator_on_o)
		else $error("slow rate seen but oscillator off");
	a_oe_idle: assert property (serial_port_select_bar_i [*4] |->
		!sdio_oe_o)
		else $error("data pin driven while deselected");
	// Pattern, enable, assignment, output-enable and pull-down outputs change only as a result of a serial write.
	a_patt_hold: assert property ($changed(user_pattern_two_o) |->
		!$past(serial_port_select_bar_i))
		else $error("pattern changed without write");
	a_or_hold: assert property ($changed(or_pin_enable_o) |->
		!$past(serial_port_select_bar_i))
		else $error("over-range enable changed without write");
	a_assign_hold: assert property ($changed(out_assign_b_o) |->
		!$past(serial_port_select_bar_i))
		else $error("assignment changed without write");
	a_oeb_hold: assert property ($changed(output_enable_bar_pin_en_o)
		|-> !$past(serial_port_select_bar_i))
		else $error("output enable changed without write");
	a_pd_hold: assert property ($changed(sdio_pulldown_en_o) |->
		!$past(serial_port_select_bar_i))
		else $error("pull-down changed without write");
endmodule

bind asfr_regs asfr_props #(.NUM_CH(NUM_CH)) u_props (.clk_i(clk_i),
	.resetn_i(resetn_i), .sync_pin_i(sync_pin_i),
	.serial_port_select_bar_i(serial_port_select_bar_i),
	.div_resync_o(div_resync_o), .sdio_oe_o(sdio_oe_o),
	.user_pattern_two_o(user_pattern_two_o),
	.or_pin_enable_o(or_pin_enable_o), .out_assign_b_o(out_assign_b_o),
	.output_enable_bar_pin_en_o(output_enable_bar_pin_en_o),
	.low_rate_internal_oscillator_on_o(low_rate_internal_oscillator_on_o),
	.low_rate_detected_o(low_rate_detected_o),
	.sdio_pulldown_en_o(sdio_pulldown_en_o));
`default_nettype wire

// [dv/asfr_host.sv]
// Purpose: Serial port host model that issues register frames.
// Assumes: Each serial clock phase lasts four system clocks.
// Notes: Serial clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module asfr_host
(
	// System clock.
	input wire logic clk_i,
	// Serial pins.
	output logic sel_n_o,
	output logic sclk_o,
	output logic sdio_o,
	input wire logic dev_sdio_i,
	input wire logic dev_oe_i,
	input wire logic pulldown_i
);
	logic hoe;
	logic hbit;
	logic idle;
	// Released line falls to the pull-down, else shows the inverse bit.
	assign idle = pulldown_i ? 1'b0 : ~hbit;
	assign sdio_o = hoe ? hbit : (dev_oe_i ? dev_sdio_i : idle);

	// Port stays idle outside frames so it adds no noise.
	initial
	begin
		sel_n_o = 1'b1;
		sclk_o = 1'b0;
		hoe = 1'b0;
		hbit = 1'b0;
	end

	// Wait n clocks, landing just after the edge.
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// One frame: instruction MSB first, then one data byte.
	task automatic frame(input logic rd, input logic [12:0] a,
		input logic [7:0] wd, output logic [7:0] rdv);
		logic [23:0] s;
		s = {rd, 2'h0, a, wd};
		rdv = 8'h00;
		wt(1);
		sel_n_o = 1'b0;
		for (int i = 23; i >= 0; i--)
		begin
			sclk_o = 1'b0;
			hoe = !(rd && i < 8);
			hbit = s[i];
			wt(4);
			if (!hoe)
				rdv[i] = sdio_o;
			sclk_o = 1'b1;
			wt(4);
		end
		sclk_o = 1'b0;
		sel_n_o = 1'b1;
		hoe = 1'b0;
		wt(4);
	endtask
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Purpose: Directed register and sync tests for the register tail.
// Assumes: Host model frames and 250 MHz system clock.
// Notes: Encode clock stops to provoke the slow-rate detector.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk, resetn, sel_n, sclk, sdio, sdo, soe, sync, enc, enc_run;
	logic tick, rsy, output_enable_bar_pin, osc, det, pd;
	logic [1:0] chs, ore, asb;
	logic [2:0] ratio;
	logic [15:0] sig, patt;
	logic [7:0] rv;
	int errors, tests_run, pulses, ticks;

	asfr_regs #(.NUM_CH(2)) uut (.clk_i(clk), .resetn_i(resetn),
		.serial_port_select_bar_i(sel_n), .sclk_i(sclk), .sdio_i(sdio),
		.sdio_o(sdo), .sdio_oe_o(soe), .chan_sel_i(chs),
		.self_test_signature_i(sig), .sync_pin_i(sync), .encode_pin_i(enc),
		.div_ratio_i(ratio), .div_tick_o(tick), .div_resync_o(rsy),
		.user_pattern_two_o(patt), .or_pin_enable_o(ore),
		.out_assign_b_o(asb), .output_enable_bar_pin_en_o(output_enable_bar_pin),
		.low_rate_internal_oscillator_on_o(osc),
		.low_rate_detected_o(det), .sdio_pulldown_en_o(pd));
	asfr_host host (.clk_i(clk), .sel_n_o(sel_n), .sclk_o(sclk),
		.sdio_o(sdio), .dev_sdio_i(sdo), .dev_oe_i(soe), .pulldown_i(pd));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Encode toggles just after each rising edge while running.
	always @(posedge clk)
	begin
		#1;
		if (enc_run)
			enc = ~enc;
	end

	// Counting mid-cycle keeps clear of the edge where counters are cleared.
	always @(negedge clk)
	begin
		pulses += int'(rsy);
		ticks += int'(tick);
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd(input logic [12:0] a, input logic [7:0] exp);
		host.frame(1'b1, a, 8'h00, rv);
		chk({8'h00, rv}, {8'h00, exp});
	endtask

	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		host.frame(1'b0, a, d, rv);
	endtask

	// Sync pin held three clocks, then the resync count is compared.
	task automatic pulse(input int n);
		pulses = 0;
		sync = 1'b1;
		host.wt(3);
		sync = 1'b0;
		host.wt(10);
		chk(16'(pulses), 16'(n));
	endtask

	task automatic end_sim;
		if (errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Bounded run; a hang counts as a mismatch.
	initial
	begin
		host.wt(30000);
		errors++;
		$display("[ERR] %0t timeout", $time);
		end_sim();
	end

	initial
	begin
		errors = 0;
		tests_run = 0;
		resetn = 1'b0;
		chs = 2'b01;
		sig = 16'hffff;
		sync = 1'b0;
		enc = 1'b0;
		enc_run = 1'b1;
		ratio = 3'h3;
		host.wt(5);
		resetn = 1'b1;
		host.wt(3);
		chk({ore, asb, output_enable_bar_pin, pd, osc}, 16'h0076);
		chk(patt, 16'h0000);
		rd(13'h001b, 8'h00);
		rd(13'h001c, 8'h00);
		rd(13'h0024, 8'h01);
		rd(13'h002a, 8'h01);
		rd(13'h002e, 8'h00);
		rd(13'h0100, 8'h01);
		rd(13'h0101, 8'h88);
		rd(13'h0050, 8'h00);
		wr(13'h001b, 8'ha5);
		wr(13'h001c, 8'h3c);
		chk(patt, 16'h3ca5);
		rd(13'h001c, 8'h3c);
		wr(13'h0024, 8'hfe);
		rd(13'h0024, 8'h01);
		sig = 16'hfffe;
		rd(13'h0024, 8'h00);
		sig = 16'h0001;
		rd(13'h0024, 8'h01);
		wr(13'h002a, 8'hff);
		rd(13'h002a, 8'h01);
		wr(13'h002a, 8'h00);
		chk({14'h0, ore}, 16'h0002);
		// Channel B alone: reads and writes reach only its local copy.
		chs = 2'b10;
		rd(13'h002a, 8'h01);
		rd(13'h002e, 8'h01);
		wr(13'h002e, 8'h00);
		chk({14'h0, asb}, 16'h0000);
		// Both channels selected: one write reaches both copies.
		chs = 2'b11;
		wr(13'h002a, 8'h01);
		chk({14'h0, ore}, 16'h0003);
		wr(13'h002e, 8'h01);
		chk({14'h0, asb}, 16'h0003);
		wr(13'h0101, 8'hff);
		rd(13'h0101, 8'h8d);
		chk({output_enable_bar_pin, pd, osc}, 16'h0005);
		wr(13'h0101, 8'h08);
		chk({output_enable_bar_pin, pd, osc}, 16'h0002);
		enc_run = 1'b0;
		host.wt(60);
		chk({det, osc}, 16'h0003);
		wr(13'h0101, 8'h00);
		chk({det, osc}, 16'h0000);
		wr(13'h0101, 8'h04);
		chk({15'h0, osc}, 16'h0001);
		// A reset in mid-run brings every register back to its default.
		enc_run = 1'b1;
		resetn = 1'b0;
		host.wt(2);
		resetn = 1'b1;
		host.wt(3);
		chk({ore, asb, output_enable_bar_pin, pd, osc}, 16'h0076);
		chk(patt, 16'h0000);
		rd(13'h0101, 8'h88);
		rd(13'h0100, 8'h01);
		ticks = 0;
		host.wt(40);
		chk(16'(ticks), 16'd10);
		ratio = 3'h1;
		host.wt(2);
		ticks = 0;
		host.wt(40);
		chk(16'(ticks), 16'd20);
		wr(13'h0100, 8'h02);
		pulse(0);
		wr(13'h0100, 8'h03);
		pulse(1);
		pulse(1);
		rd(13'h0100, 8'h03);
		wr(13'h0100, 8'h07);
		pulse(1);
		rd(13'h0100, 8'h05);
		pulse(0);
		wr(13'h0100, 8'h01);
		pulse(0);
		end_sim();
	end
endmodule
`default_nettype wire
